/* dte_tag_expander.sv */
`timescale 1ns/1ns
`include "dte_cfg.svh"

module dte_tag_expander (
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Word stream from host memory
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [`DTE_WORD_W-1:0] in_word,
  input  wire logic                   target_three_d,
  // Pair output to the two pipeline input FIFOs
  output logic                        two_d_input_fifo_valid,
  input  wire logic                   two_d_input_fifo_ready,
  output logic                        three_d_input_fifo_valid,
  input  wire logic                   three_d_input_fifo_ready,
  output logic [`DTE_ITAG_W-1:0]      pair_tag,
  output logic [`DTE_WORD_W-1:0]      pair_data,
  // Read back port
  input  wire logic                   rb_rd_en,
  input  wire logic [`DTE_TAG_W-1:0]  rb_rd_addr,
  output logic [`DTE_WORD_W-1:0]      rb_rd_data,
  output logic                        rb_rd_valid,
  // Status
  output logic                        busy
);

  dte_pkg::dte_state_t      state_ff;
  dte_pkg::dte_state_t      nxt_state;
  dte_pkg::dte_mode_t       mode_ff;
  dte_pkg::dte_mode_t       nxt_mode;
  logic [`DTE_TAG_W-1:0]    tag_ff;
  logic [`DTE_TAG_W-1:0]    nxt_tag;
  logic [`DTE_CM_W-1:0]     cm_ff;
  logic [`DTE_CM_W-1:0]     nxt_cm;
  logic                     ctx_ff;
  logic                     nxt_ctx;

  logic                     out_valid_ff;
  logic                     nxt_out_valid;
  logic                     out_sel_ff;
  logic                     nxt_out_sel;
  logic [`DTE_ITAG_W-1:0]   out_tag_ff;
  logic [`DTE_ITAG_W-1:0]   nxt_out_tag;
  logic [`DTE_WORD_W-1:0]   out_data_ff;
  logic [`DTE_WORD_W-1:0]   nxt_out_data;

  logic                     sel_ready;
  logic                     out_fire;
  logic                     slot_free;
  logic                     in_fire;
  logic [`DTE_OFS_W-1:0]    low_ofs;
  logic [`DTE_TAG_W-1:0]    gen_tag;
  logic                     last_word;

  // Fields of the word on offer
  logic [`DTE_TAG_W-1:0]    word_tag;
  logic [`DTE_CM_W-1:0]     word_cm;
  dte_pkg::dte_mode_t       word_mode;
  logic                     word_empty;

  // Registered status
  logic                     nxt_busy;
  logic                     busy_ff;

  dte_rb_if rb ();

  // Lowest set mask bit gives the next offset
  function automatic logic [`DTE_OFS_W-1:0] dte_lowest(input logic [`DTE_CM_W-1:0] m);
    logic [`DTE_OFS_W-1:0] r;
    r = `DTE_OFS_ZERO;
    // Walking downward leaves the lowest set bit as the last one written
    for (int i = `DTE_CM_W - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = i[`DTE_OFS_W-1:0];
      end
    end
    return r;
  endfunction

  // Output slot drains only into a FIFO with room
  // A refused pair keeps its tag and data; data words on the input side wait instead, tag words are still taken
  assign sel_ready = out_sel_ff ? three_d_input_fifo_ready : two_d_input_fifo_ready;
  assign out_fire  = out_valid_ff && sel_ready;
  assign slot_free = !out_valid_ff || sel_ready;

  // Tag words are always taken; data words wait for a free slot
  always_comb begin
    if (state_ff == dte_pkg::DTE_ST_DATA) begin
      in_ready = slot_free;
    end else begin
      in_ready = 1'b1;
    end
  end
  assign in_fire = in_valid && in_ready;

  assign word_tag = in_word[`DTE_TAG_HI:`DTE_TAG_LO];
  assign word_cm  = in_word[`DTE_CM_HI:`DTE_CM_LO];

  // Indexed wins if both mode bits are set
  always_comb begin
    if (in_word[`DTE_IDX_BIT]) begin
      word_mode = dte_pkg::DTE_MODE_IDX;
    end else if (in_word[`DTE_INC_BIT]) begin
      word_mode = dte_pkg::DTE_MODE_INC;
    end else begin
      word_mode = dte_pkg::DTE_MODE_HOLD;
    end
  end

  // An empty mask names no offset, so no data word may follow it
  assign word_empty = (word_mode == dte_pkg::DTE_MODE_IDX) && (word_cm == `DTE_CM_ZERO);

  // Ascending offset order within the mask
  assign low_ofs = dte_lowest(cm_ff);

  always_comb begin
    case (mode_ff)
      // Mask bit picks offset; group kept, offset field unused
      dte_pkg::DTE_MODE_IDX: begin
        gen_tag = {tag_ff[`DTE_GRP_HI:`DTE_GRP_LO], low_ofs};
      end
      default: begin
        gen_tag = tag_ff;
      end
    endcase
  end

  always_comb begin
    case (mode_ff)
      dte_pkg::DTE_MODE_IDX: begin
        last_word = ((cm_ff & (cm_ff - `DTE_CM_ONE)) == `DTE_CM_ZERO);
      end
      default: begin
        // Count of zero is the final word
        last_word = (cm_ff == `DTE_CM_ZERO);
      end
    endcase
  end

  // Expansion state
  always_comb begin
    nxt_state = state_ff;
    nxt_mode  = mode_ff;
    nxt_tag   = tag_ff;
    nxt_cm    = cm_ff;
    nxt_ctx   = ctx_ff;
    case (state_ff)
      dte_pkg::DTE_ST_TAGWORD: begin
        if (in_fire) begin
          // Split the tag word into its fields
          nxt_tag  = word_tag;
          nxt_cm   = word_cm;
          nxt_ctx  = target_three_d;
          // Mode decides how count-or-mask is read
          nxt_mode = word_mode;
          if (word_empty) begin
            nxt_state = dte_pkg::DTE_ST_TAGWORD;
          end else begin
            nxt_state = dte_pkg::DTE_ST_DATA;
          end
        end
      end
      dte_pkg::DTE_ST_DATA: begin
        if (in_fire) begin
          case (mode_ff)
            dte_pkg::DTE_MODE_IDX: begin
              // Retire the bit just used
              nxt_cm = cm_ff & (cm_ff - `DTE_CM_ONE);
            end
            dte_pkg::DTE_MODE_INC: begin
              // Step the tag for the next word
              nxt_tag = tag_ff + `DTE_TAG_ONE;
              nxt_cm  = cm_ff - `DTE_CM_ONE;
            end
            default: begin
              nxt_cm = cm_ff - `DTE_CM_ONE;
            end
          endcase
          // Local count only, no transfer length involved
          if (last_word) begin
            nxt_state = dte_pkg::DTE_ST_TAGWORD;
          end
        end
      end
      default: begin
        nxt_state = dte_pkg::DTE_ST_TAGWORD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= dte_pkg::DTE_ST_TAGWORD;
      mode_ff  <= dte_pkg::DTE_MODE_HOLD;
      tag_ff   <= `DTE_TAG_ZERO;
      cm_ff    <= `DTE_CM_ZERO;
      ctx_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      mode_ff  <= nxt_mode;
      tag_ff   <= nxt_tag;
      cm_ff    <= nxt_cm;
      ctx_ff   <= nxt_ctx;
    end
  end

  // Output slot: one registered pair, refilled in the cycle it drains
  always_comb begin
    nxt_out_valid = out_valid_ff;
    nxt_out_sel   = out_sel_ff;
    nxt_out_tag   = out_tag_ff;
    nxt_out_data  = out_data_ff;
    if (out_fire) begin
      nxt_out_valid = 1'b0;
    end
    // Data word becomes a pair for the selected FIFO
    if (in_fire && (state_ff == dte_pkg::DTE_ST_DATA)) begin
      nxt_out_valid = 1'b1;
      nxt_out_sel   = ctx_ff;
      // Context bit above the 9-bit grouped tag
      nxt_out_tag   = {ctx_ff, gen_tag};
      nxt_out_data  = in_word;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_valid_ff <= 1'b0;
      out_sel_ff   <= 1'b0;
      out_tag_ff   <= {1'b0, `DTE_TAG_ZERO};
      out_data_ff  <= `DTE_WORD_ZERO;
    end else begin
      out_valid_ff <= nxt_out_valid;
      out_sel_ff   <= nxt_out_sel;
      out_tag_ff   <= nxt_out_tag;
      out_data_ff  <= nxt_out_data;
    end
  end

  // Status follows the next values so it changes in step with the state it reports
  always_comb begin
    if (nxt_state != dte_pkg::DTE_ST_TAGWORD) begin
      nxt_busy = 1'b1;
    end else begin
      nxt_busy = nxt_out_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
    end
  end

  assign two_d_input_fifo_valid   = out_valid_ff && !out_sel_ff;
  assign three_d_input_fifo_valid = out_valid_ff && out_sel_ff;
  assign pair_tag                 = out_tag_ff;
  assign pair_data                = out_data_ff;
  assign busy                     = busy_ff;

  // Delivered messages go to read back, which records only the readable offsets of group 0
  assign rb.wr_en   = out_fire;
  assign rb.wr_tag  = out_tag_ff[`DTE_TAG_W-1:0];
  assign rb.wr_data = out_data_ff;
  assign rb.rd_en   = rb_rd_en;
  assign rb.rd_addr = rb_rd_addr;
  assign rb_rd_data  = rb.rd_data;
  assign rb_rd_valid = rb.rd_valid;

  dte_readback u_readback (
    .clk (clk),
    .rst (rst),
    .rb  (rb.store)
  );

endmodule

/* dte_cfg.svh */
`ifndef DTE_CFG_SVH
`define DTE_CFG_SVH

// Tag word layout
`define DTE_CM_HI        31
`define DTE_CM_LO        16
`define DTE_IDX_BIT      15
`define DTE_INC_BIT      14
`define DTE_TAG_HI       8
`define DTE_TAG_LO       0
`define DTE_GRP_HI       8
`define DTE_GRP_LO       4
`define DTE_OFS_HI       3
`define DTE_OFS_LO       0

// Widths
`define DTE_WORD_W       32
`define DTE_TAG_W        9
`define DTE_ITAG_W       10
`define DTE_CM_W         16
`define DTE_GRP_W        5
`define DTE_OFS_W        4
`define DTE_RB_DEPTH     16

// Constants
`define DTE_CM_ZERO      16'h0000
`define DTE_CM_ONE       16'h0001
`define DTE_TAG_ZERO     9'h000
`define DTE_TAG_ONE      9'h001
`define DTE_WORD_ZERO    32'h00000000
`define DTE_OFS_ZERO     4'h0

// Read back store: one major group, readable offsets and defined bits
`define DTE_RB_GROUP     5'h00
`define DTE_RB_READABLE  16'h007F
`define DTE_RB_BITMASK   32'hFFFFFFFF

`endif

/* dte_pkg.sv */
package dte_pkg;
  typedef enum logic [0:0] {
    DTE_ST_TAGWORD = 1'b0,
    DTE_ST_DATA    = 1'b1
  } dte_state_t;

  typedef enum logic [1:0] {
    DTE_MODE_HOLD = 2'b00,
    DTE_MODE_INC  = 2'b01,
    DTE_MODE_IDX  = 2'b10
  } dte_mode_t;
endpackage

/* dte_rb_if.sv */
`timescale 1ns/1ns
`include "dte_cfg.svh"

interface dte_rb_if;
  logic                      wr_en;
  logic [`DTE_TAG_W-1:0]     wr_tag;
  logic [`DTE_WORD_W-1:0]    wr_data;
  logic                      rd_en;
  logic [`DTE_TAG_W-1:0]     rd_addr;
  logic [`DTE_WORD_W-1:0]    rd_data;
  logic                      rd_valid;

  modport store (
    input  wr_en,
    input  wr_tag,
    input  wr_data,
    input  rd_en,
    input  rd_addr,
    output rd_data,
    output rd_valid
  );

  modport user (
    output wr_en,
    output wr_tag,
    output wr_data,
    output rd_en,
    output rd_addr,
    input  rd_data,
    input  rd_valid
  );
endinterface

/* dte_readback.sv */
`timescale 1ns/1ns
`include "dte_cfg.svh"

module dte_readback (
  input  wire logic clk,
  input  wire logic rst,
  dte_rb_if.store   rb
);
  logic [`DTE_WORD_W-1:0] store_ff [`DTE_RB_DEPTH];
  logic [`DTE_WORD_W-1:0] nxt_store [`DTE_RB_DEPTH];
  logic [`DTE_WORD_W-1:0] rd_data_ff;
  logic [`DTE_WORD_W-1:0] nxt_rd_data;
  logic                   rd_valid_ff;
  logic                   nxt_rd_valid;
  logic                   wr_hit;
  logic                   rd_hit;
  logic [`DTE_OFS_W-1:0]  wr_idx;
  logic [`DTE_OFS_W-1:0]  rd_idx;
  logic [`DTE_CM_W-1:0]   readable;

  assign wr_idx = rb.wr_tag[`DTE_OFS_HI:`DTE_OFS_LO];
  assign rd_idx = rb.rd_addr[`DTE_OFS_HI:`DTE_OFS_LO];
  // A literal cannot be indexed, so the readable offsets live in a vector
  assign readable = `DTE_RB_READABLE;
  assign wr_hit = (rb.wr_tag[`DTE_GRP_HI:`DTE_GRP_LO] == `DTE_RB_GROUP)
                  && readable[wr_idx];
  assign rd_hit = (rb.rd_addr[`DTE_GRP_HI:`DTE_GRP_LO] == `DTE_RB_GROUP)
                  && readable[rd_idx];

  always_comb begin
    nxt_store = store_ff;
    if (rb.wr_en && wr_hit) begin
      nxt_store[wr_idx] = rb.wr_data;
    end
    nxt_rd_valid = rb.rd_en;
    nxt_rd_data  = `DTE_WORD_ZERO;
    // Stored value back; unknown or write-only reads zero
    if (rb.rd_en && rd_hit) begin
      nxt_rd_data = store_ff[rd_idx] & `DTE_RB_BITMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < `DTE_RB_DEPTH; i++) begin
        store_ff[i] <= `DTE_WORD_ZERO;
      end
      rd_data_ff  <= `DTE_WORD_ZERO;
      rd_valid_ff <= 1'b0;
    end else begin
      store_ff    <= nxt_store;
      rd_data_ff  <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  assign rb.rd_data  = rd_data_ff;
  assign rb.rd_valid = rd_valid_ff;
endmodule

/* dte_tag_expander_assertions.sv */
`timescale 1ns/1ns
`include "dte_cfg.svh"
module dte_tag_expander_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        in_ready,
  input wire logic        two_d_input_fifo_valid,
  input wire logic        two_d_input_fifo_ready,
  input wire logic        three_d_input_fifo_valid,
  input wire logic        three_d_input_fifo_ready,
  input wire logic [9:0]  pair_tag,
  input wire logic [31:0] pair_data,
  input wire logic        rb_rd_en,
  input wire logic [8:0]  rb_rd_addr,
  input wire logic [31:0] rb_rd_data,
  input wire logic        rb_rd_valid,
  input wire logic        busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_hold_two_d: assert property (two_d_input_fifo_valid && !two_d_input_fifo_ready
    |=> two_d_input_fifo_valid && $stable(pair_tag) && $stable(pair_data))
    else $error("2D pair changed before taken");
  a_hold_three_d: assert property (three_d_input_fifo_valid && !three_d_input_fifo_ready
    |=> three_d_input_fifo_valid && $stable(pair_tag) && $stable(pair_data))
    else $error("3D pair changed before taken");
  a_one_target: assert property (!(two_d_input_fifo_valid && three_d_input_fifo_valid))
    else $error("both FIFOs offered a pair");
  a_ctx_two_d: assert property (two_d_input_fifo_valid |-> !pair_tag[9])
    else $error("2D pair has context set");
  a_ctx_three_d: assert property (three_d_input_fifo_valid |-> pair_tag[9])
    else $error("3D pair has context clear");
  a_refuse_full: assert property (!in_ready |->
    (two_d_input_fifo_valid && !two_d_input_fifo_ready) ||
    (three_d_input_fifo_valid && !three_d_input_fifo_ready))
    else $error("input refused with room downstream");
  a_idle_ready: assert property (!busy |-> in_ready)
    else $error("idle expander refused a tag word");
  a_rb_answer: assert property (rb_rd_en |=> rb_rd_valid)
    else $error("read back not answered");
  a_rb_pulse: assert property (rb_rd_valid |-> $past(rb_rd_en))
    else $error("read back answer without request");
  a_rb_zero: assert property (rb_rd_valid && $past(rb_rd_addr) > 9'h006
    |-> rb_rd_data == 32'h00000000)
    else $error("unreadable message not zero");
endmodule
bind dte_tag_expander dte_tag_expander_assertions chk (.clk, .rst, .in_ready,
  .two_d_input_fifo_valid, .two_d_input_fifo_ready, .three_d_input_fifo_valid,
  .three_d_input_fifo_ready, .pair_tag, .pair_data, .rb_rd_en, .rb_rd_addr,
  .rb_rd_data, .rb_rd_valid, .busy);

/* dte_fifo_sink.sv */
`timescale 1ns/1ns
module dte_fifo_sink (
  input wire logic clk,
  input wire logic stall,
  output logic     ready
);
  // While stall is set, room comes and goes at random, also while a pair waits; with stall clear, ready stays high
  always @(posedge clk) begin
    ready <= !stall || $urandom_range(1);
  end
endmodule

/* dte_tag_expander_test.sv */
`timescale 1ns/1ns
module dte_tag_expander_test;
  logic        clk = 0, rst = 1, iv = 0, t3 = 0, stall = 0, re = 0;
  logic [31:0] iw = 32'h00000000, rd, pd;
  logic [8:0]  ra = 9'h000;
  logic [9:0]  pt;
  logic        ir, v2, r2, v3, r3, rv, bz;
  logic [41:0] exq[$];
  logic [31:0] sh[16];
  int          n_errors = 0, num_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  dte_tag_expander dut (.clk, .rst, .in_valid(iv), .in_ready(ir), .in_word(iw),
    .target_three_d(t3), .two_d_input_fifo_valid(v2), .two_d_input_fifo_ready(r2),
    .three_d_input_fifo_valid(v3), .three_d_input_fifo_ready(r3), .pair_tag(pt),
    .pair_data(pd), .rb_rd_en(re), .rb_rd_addr(ra), .rb_rd_data(rd),
    .rb_rd_valid(rv), .busy(bz));
  dte_fifo_sink f2 (.clk, .stall, .ready(r2));
  dte_fifo_sink f3 (.clk, .stall, .ready(r3));
  function automatic int cnt(logic [31:0] w);
    return w[15] ? $countones(w[31:16]) : w[31:16] + 1;
  endfunction
  function automatic logic [8:0] tg(logic [31:0] w, int i);
    int k = -1;
    if (!w[15]) return w[14] ? w[8:0] + i[8:0] : w[8:0];
    for (int b = 0; b < 16; b++) begin
      if (w[16+b]) begin
        k++;
        if (k == i) return {w[8:4], b[3:0]};
      end
    end
    return 9'h000;
  endfunction
  task chk(input logic [41:0] g, input logic [41:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task chk_rb(input logic v, input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (v !== 1'b1 || g !== e) begin
      n_errors++;
      $display("[FAIL] %0t read back valid %b got %h expected %h", $time, v, g, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task put(input logic [31:0] w);
    bit ok;
    iv <= 1;
    iw <= w;
    do begin
      @(negedge clk);
      ok = ir;
      @(posedge clk);
    end while (!ok);
  endtask
  task pkt(input logic [31:0] w, input logic c);
    logic [31:0] d;
    t3 <= c;
    put(w);
    for (int i = 0; i < cnt(w); i++) begin
      d = $urandom;
      exq.push_back({c, tg(w, i), d});
      put(d);
    end
  endtask
  task drain(input string s);
    int t;
    t = 0;
    iv <= 0;
    do begin
      @(negedge clk);
      t++;
    end while ((exq.size() != 0 || bz !== 1'b0) && t < 3000);
    if (t >= 3000) chk(42'h00000000000, 42'h00000000001);
    @(posedge clk);
    $display("test %s done", s);
  endtask
  task rd_chk(input logic [8:0] a);
    logic [31:0] e;
    e = (a < 9'h007) ? sh[a[3:0]] : 32'h00000000;
    re <= 1;
    ra <= a;
    @(posedge clk);
    re <= 0;
    @(negedge clk);
    chk_rb(rv, rd, e);
    @(posedge clk);
  endtask
  // Expected pairs leave the queue as the FIFO takes them
  always @(negedge clk) begin
    logic [41:0] e;
    if (!rst && (v2 && r2 || v3 && r3)) begin
      e = 42'h3FFFFFFFFFF;
      if (exq.size() != 0) e = exq.pop_front();
      if (e[40:36] == 5'h00) sh[e[35:32]] = e[31:0];
      chk({pt, pd}, e);
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      wrap_up;
    end
  end
  initial begin
    logic [31:0] w;
    void'($urandom(38));
    repeat (6) @(posedge clk);
    rst <= 0;
    pkt(32'h02038000, 1'b0);
    drain("indexed");
    pkt(32'h00000012, 1'b1);
    pkt(32'h0003015A, 1'b0);
    pkt(32'h0004400E, 1'b1);
    pkt(32'h8001C1F7, 1'b0);
    pkt(32'h0000C000, 1'b1);
    drain("modes");
    stall <= 1;
    repeat (40) begin
      w = $urandom;
      if (!w[15]) w[31:20] = 12'h000;
      pkt(w, 1'($urandom_range(1)));
    end
    drain("random");
    pkt(32'h00064000, 1'b0);
    pkt(32'h00010005, 1'b1);
    drain("fill");
    stall <= 0;
    for (int a = 0; a < 16; a++) rd_chk(a[8:0]);
    rd_chk(9'h1F0);
    rd_chk(9'h013);
    $display("test readback done");
    wrap_up;
  end
endmodule
